// ===== pin_partner.sv
// Outside world seen by the timer pins: channel pin levels and the external clock
module pin_partner #(
  parameter int N = 2
) (
  input wire logic core_clk_i,
  input wire logic [N-1:0] pin_drv_i,
  input wire logic [N-1:0] pin_oe_i,
  output logic [N-1:0] pin_lvl_o,
  output logic ext_clk_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [N-1:0] outside_r;

  // Quiet pins and a still clock until a test asks for activity
  initial begin
    outside_r = '0;
    ext_clk_o = 1'b0;
  end

  // Pin level: the timer wins where it drives, else the outside source
  assign pin_lvl_o = (pin_oe_i & pin_drv_i) | (~pin_oe_i & outside_r);

  // New outside level, held long past the shortest pulse the timer can see
  task automatic set_level(input logic [N-1:0] v);
    @(posedge core_clk_i);
    outside_r <= v;
    repeat (6) @(posedge core_clk_i);
  endtask

  // Burst of rising edges at a quarter of the bus rate, low between bursts
  task automatic ext_pulses(input int n);
    repeat (n) begin
      @(posedge core_clk_i);
      ext_clk_o <= 1'b1;
      repeat (2) @(posedge core_clk_i);
      ext_clk_o <= 1'b0;
      @(posedge core_clk_i);
    end
    repeat (5) @(posedge core_clk_i);
    #1;
  endtask
endmodule // pin_partner

// ===== sync_edge.sv
// Two-stage synchroniser with edge detection on the synchronised level
module sync_edge #(
  parameter int W = 1
) (
  input wire logic core_clk_i,
  input wire logic rstn_i,
  input wire logic [W-1:0] async_i,
  output logic [W-1:0] level_o,
  output logic [W-1:0] rise_o,
  output logic [W-1:0] fall_o
);
  logic [W-1:0] meta_r;
  logic [W-1:0] sync_r;
  logic [W-1:0] prev_r;

  // First stage feeds only the second stage
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      meta_r <= '0;
      sync_r <= '0;
      prev_r <= '0;
    end else begin
      meta_r <= async_i;
      sync_r <= meta_r;
      prev_r <= sync_r;
    end
  end

  // Edges come from the stable stages only
  assign level_o = sync_r;
  assign rise_o = sync_r & ~prev_r;
  assign fall_o = ~sync_r & prev_r;
endmodule // sync_edge

// ===== timer_channel_pin_control.sv
// Timer/PWM unit: clock select, counter, channel pin ownership, capture, compare and PWM
// Behaviour
// - Software picks counter clock from three sources, or none
// - External clock synchronised; source below quarter rate
// - External clock pin still allows software compare
// - Pin released when edge select or clock off
// - Center-align mode drives all enabled channel pins
// - Mode select picks capture, compare, edge PWM
// - Capture mode makes pin an edge input
// - Capture edges synchronised; polarity from edge select
// - Compare match toggles, clears or sets pin
// - Toggle keeps existing level until first match
// - Edge PWM high at zero, low at match
// - Edge PWM inverted: high at match
// - Center PWM clear up-match, set down-match
// - Clock select 00 off, 01 bus, 10 fixed, 11 external
// - Center mode counts up to modulo then down
//
// The APB register port and the placing of the registers were decided locally.
module timer_channel_pin_control #(
  parameter int NUM_CH = 2
) (
  input wire logic core_clk_i,
  input wire logic rstn_i,
  input wire logic [timer_pkg::ADDR_W-1:0] paddr_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic fixed_clk_tick_i,
  input wire logic external_timer_clock_input_i,
  input wire logic [NUM_CH-1:0] channel_pin_i,
  output logic [NUM_CH-1:0] channel_pin_o,
  output logic [NUM_CH-1:0] channel_pin_oe_o,
  output logic [NUM_CH-1:0] channel_owned_o
);
  import timer_pkg::*;

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [2:0] ps_r;
  logic [1:0] cks_r, els_r [NUM_CH], mode_r [NUM_CH];
  logic center_aligned_pwm_r, up_r, src_tick, cnt_tick, cnt_upd_r, up_nxt, wr_en, hit, ch_hit, period_start;
  logic [CNT_W-1:0] cnt_r, mod_r, cnt_nxt, val_r [NUM_CH];
  logic [6:0] pre_r, pre_mask;
  logic flag_r [NUM_CH], out_r [NUM_CH], was_oe_r [NUM_CH], match [NUM_CH];
  logic [NUM_CH:0] sync_lvl, sync_rise, sync_fall;
  logic [ADDR_W-1:0] ch_ofs;
  logic [ADDR_W-4:0] ch_idx;
  logic [31:0] rd_nxt;
  // ----------------------------------------------------------------
  // Synchronisers for external clock and channel inputs
  // ----------------------------------------------------------------
  sync_edge #(.W(NUM_CH + 1)) u_sync (
    .core_clk_i(core_clk_i),
    .rstn_i(rstn_i),
    .async_i({external_timer_clock_input_i, channel_pin_i}),
    .level_o(sync_lvl),
    .rise_o(sync_rise),
    .fall_o(sync_fall)
  );
  // ----------------------------------------------------------------
  // APB slave: zero wait state, error on unmapped address
  // ----------------------------------------------------------------
  assign ch_ofs = paddr_i - CH_BASE_OFS;
  assign ch_idx = ch_ofs[ADDR_W-1:3];
  assign ch_hit = (paddr_i >= CH_BASE_OFS) && (int'(ch_idx) < NUM_CH) && (paddr_i[1:0] == 2'h0);
  assign hit = ch_hit || paddr_i == CTRL_OFS || paddr_i == CNT_OFS
               || paddr_i == MOD_OFS || paddr_i == FLAG_OFS;
  assign pready_o = 1'b1;
  assign pslverr_o = psel_i && penable_i && !hit;
  assign wr_en = psel_i && penable_i && pwrite_i && hit;
  // Read mux, sampled in the setup cycle
  always_comb begin
    rd_nxt = 32'h0000_0000;
    case (paddr_i)
      CTRL_OFS: begin
        rd_nxt[PS_LSB +: 3] = ps_r;
        rd_nxt[CKS_LSB +: 2] = cks_r;
        rd_nxt[CENTER_ALIGNED_PWM_BIT] = center_aligned_pwm_r;
      end
      CNT_OFS: rd_nxt[CNT_W-1:0] = cnt_r;
      MOD_OFS: rd_nxt[CNT_W-1:0] = mod_r;
      FLAG_OFS: begin
        for (int i = 0; i < NUM_CH; i++) begin
          rd_nxt[i] = flag_r[i];
        end
        rd_nxt[DIR_BIT] = up_r;
      end
      default: begin
        for (int i = 0; i < NUM_CH; i++) begin
          if (ch_hit && int'(ch_idx) == i) begin
            if (ch_ofs[2:0] == CH_VAL_OFS[2:0]) begin
              rd_nxt[CNT_W-1:0] = val_r[i];
            end else begin
              rd_nxt[ELS_LSB +: 2] = els_r[i];
              rd_nxt[MODE_LSB +: 2] = mode_r[i];
            end
          end
        end
      end
    endcase
  end

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      prdata_o <= 32'h0000_0000;
    end else if (psel_i && !penable_i) begin
      prdata_o <= rd_nxt;
    end
  end
  // Global control and modulo registers
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ps_r <= 3'h0;
      cks_r <= CKS_OFF;
      center_aligned_pwm_r <= 1'b0;
      mod_r <= MOD_RST;
    end else if (wr_en) begin
      if (paddr_i == CTRL_OFS) begin
        ps_r <= pwdata_i[PS_LSB +: 3];
        cks_r <= pwdata_i[CKS_LSB +: 2];
        center_aligned_pwm_r <= pwdata_i[CENTER_ALIGNED_PWM_BIT];
      end
      if (paddr_i == MOD_OFS) begin
        mod_r <= pwdata_i[CNT_W-1:0];
      end
    end
  end
  // ----------------------------------------------------------------
  // Clock source select and prescaler
  // ----------------------------------------------------------------
  always_comb begin
    case (cks_r)
      CKS_BUS: src_tick = 1'b1;
      CKS_FIXED: src_tick = fixed_clk_tick_i;
      CKS_EXT: src_tick = sync_rise[NUM_CH];
      default: src_tick = 1'b0;
    endcase
  end

  assign pre_mask = 7'((8'h01 << ps_r) - 8'h01);
  assign cnt_tick = src_tick && ((pre_r & pre_mask) == pre_mask);

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pre_r <= PRE_RST;
    end else if (src_tick) begin
      pre_r <= pre_r + 7'h01;
    end
  end

  // ----------------------------------------------------------------
  // Counter: free-running/modulo up, or up/down in center mode
  // ----------------------------------------------------------------
  always_comb begin
    up_nxt = 1'b1;
    cnt_nxt = cnt_r + 16'h0001;
    if (center_aligned_pwm_r) begin
      up_nxt = up_r;
      if (up_r && cnt_r >= mod_r) begin
        up_nxt = 1'b0;
        cnt_nxt = cnt_r - 16'h0001;
      end else if (!up_r && cnt_r == CNT_RST) begin
        up_nxt = 1'b1;
      end else if (!up_r) begin
        cnt_nxt = cnt_r - 16'h0001;
      end
    end else if (cnt_r == mod_r && mod_r != MOD_RST) begin
      cnt_nxt = CNT_RST;
    end
  end

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cnt_r <= CNT_RST;
      up_r <= 1'b1;
      cnt_upd_r <= 1'b0;
    end else if (wr_en && paddr_i == CNT_OFS) begin
      cnt_r <= CNT_RST; // Any write restarts the count
      up_r <= 1'b1;
      cnt_upd_r <= 1'b0;
    end else begin
      cnt_upd_r <= cnt_tick;
      if (cnt_tick) begin
        cnt_r <= cnt_nxt;
        up_r <= up_nxt;
      end
    end
  end

  assign period_start = cnt_upd_r && cnt_r == CNT_RST;
  // ----------------------------------------------------------------
  // Channels
  // ----------------------------------------------------------------
  for (genvar n = 0; n < NUM_CH; n++) begin : g_ch
    logic sel, cap_edge;
    assign sel = wr_en && ch_hit && int'(ch_idx) == n;
    // Pin ownership and direction
    assign channel_owned_o[n] = els_r[n] != ELS_NONE && cks_r != CKS_OFF;
    assign channel_pin_oe_o[n] = channel_owned_o[n]
                                 && (center_aligned_pwm_r || mode_r[n] != MODE_CAPTURE);
    assign channel_pin_o[n] = out_r[n];
    assign match[n] = cnt_upd_r && cnt_r == val_r[n];
    // Capture edge polarity from edge select
    always_comb begin
      case (els_r[n])
        ELS_TOGGLE: cap_edge = sync_rise[n];
        ELS_CLEAR: cap_edge = sync_fall[n];
        ELS_SET: cap_edge = sync_rise[n] | sync_fall[n];
        default: cap_edge = 1'b0;
      endcase
    end

    // Channel control and value registers, capture loads the value
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
        els_r[n] <= ELS_NONE;
        mode_r[n] <= MODE_CAPTURE;
        val_r[n] <= CNT_RST;
      end else if (!center_aligned_pwm_r && mode_r[n] == MODE_CAPTURE && channel_owned_o[n] && cap_edge) begin
        val_r[n] <= cnt_r;
      end else if (sel && ch_ofs[2:0] == CH_VAL_OFS[2:0]) begin
        val_r[n] <= pwdata_i[CNT_W-1:0];
      end else if (sel) begin
        els_r[n] <= pwdata_i[ELS_LSB +: 2];
        mode_r[n] <= pwdata_i[MODE_LSB +: 2];
      end
    end

    // Channel flag: write one clears, a new event wins over the clear
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
        flag_r[n] <= 1'b0;
      end else if ((!center_aligned_pwm_r && mode_r[n] == MODE_CAPTURE) ? (channel_owned_o[n] && cap_edge)
                   : match[n]) begin
        flag_r[n] <= 1'b1;
      end else if (wr_en && paddr_i == FLAG_OFS && pwdata_i[n]) begin
        flag_r[n] <= 1'b0;
      end
    end

    // Output level per mode; takeover starts from the pin level seen before driving
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
        out_r[n] <= 1'b0;
        was_oe_r[n] <= 1'b0;
      end else begin
        was_oe_r[n] <= channel_pin_oe_o[n];
        if (channel_pin_oe_o[n] && !was_oe_r[n]) begin
          out_r[n] <= sync_lvl[n];
        end else if (channel_pin_oe_o[n] && center_aligned_pwm_r) begin
          if (match[n]) begin
            out_r[n] <= up_r ? els_r[n][0] : !els_r[n][0];
          end
        end else if (channel_pin_oe_o[n] && mode_r[n] == MODE_COMPARE) begin
          if (match[n]) begin
            case (els_r[n])
              ELS_TOGGLE: out_r[n] <= !out_r[n];
              ELS_CLEAR: out_r[n] <= 1'b0;
              default: out_r[n] <= 1'b1;
            endcase
          end
        end else if (channel_pin_oe_o[n]) begin
          if (match[n]) begin
            out_r[n] <= els_r[n][0];
          end else if (period_start) begin
            out_r[n] <= !els_r[n][0];
          end
        end
      end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    pin_release_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
      (els_r[n] == ELS_NONE || cks_r == CKS_OFF) |-> !channel_pin_oe_o[n] && !channel_owned_o[n])
      else $error("pin driven while released");
    center_aligned_pwm_drive_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
      (center_aligned_pwm_r && channel_owned_o[n]) |-> channel_pin_oe_o[n])
      else $error("center pwm pin not driven");
    capture_input_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
      (!center_aligned_pwm_r && mode_r[n] == MODE_CAPTURE && channel_owned_o[n] && $past(cap_edge)
       && $past(!center_aligned_pwm_r && mode_r[n] == MODE_CAPTURE && channel_owned_o[n] && !sel))
      |-> !channel_pin_oe_o[n] && val_r[n] == $past(cnt_r))
      else $error("capture value wrong");
    compare_set_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
      (!center_aligned_pwm_r && mode_r[n] == MODE_COMPARE && els_r[n] == ELS_SET && was_oe_r[n]
       && channel_pin_oe_o[n] && match[n]) |=> out_r[n])
      else $error("compare set missing");
    toggle_hold_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
      (!center_aligned_pwm_r && mode_r[n] == MODE_COMPARE && els_r[n] == ELS_TOGGLE && was_oe_r[n]
       && channel_pin_oe_o[n] && !match[n]) |=> $stable(out_r[n]))
      else $error("toggle changed without match");
    epwm_start_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
      (!center_aligned_pwm_r && mode_r[n][1] && els_r[n] == ELS_CLEAR && was_oe_r[n]
       && channel_pin_oe_o[n] && period_start && !match[n]) |=> out_r[n])
      else $error("edge pwm not high at period start");
    epwm_inv_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
      (!center_aligned_pwm_r && mode_r[n][1] && els_r[n][0] && was_oe_r[n]
       && channel_pin_oe_o[n] && match[n]) |=> out_r[n])
      else $error("inverted edge pwm not high at match");
    center_aligned_pwm_up_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
      (center_aligned_pwm_r && els_r[n] == ELS_CLEAR && was_oe_r[n] && channel_pin_oe_o[n] && match[n])
      |=> out_r[n] == !$past(up_r))
      else $error("center pwm action wrong");
    center_aligned_pwm_inv_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
      (center_aligned_pwm_r && els_r[n][0] && was_oe_r[n] && channel_pin_oe_o[n] && match[n])
      |=> out_r[n] == $past(up_r))
      else $error("inverted center pwm action wrong");
  end

  clock_off_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    (cks_r == CKS_OFF && !(wr_en && paddr_i == CNT_OFS)) |=> $stable(cnt_r))
    else $error("counter moved with clock off");
  ext_sync_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    (cks_r == CKS_EXT && src_tick) |-> $past(external_timer_clock_input_i, 2))
    else $error("external tick not synchronised");
  center_aligned_pwm_bound_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    (center_aligned_pwm_r && cnt_upd_r && !up_r && $past(up_r) && $past(center_aligned_pwm_r))
    |-> cnt_r == $past(mod_r) - 16'h0001)
    else $error("center count did not turn at modulo");
  cnt_reset_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    (wr_en && paddr_i == CNT_OFS) |=> cnt_r == CNT_RST)
    else $error("counter write did not restart");

  center_aligned_pwm_turn_c: cover property (@(posedge core_clk_i) disable iff (!rstn_i)
    center_aligned_pwm_r && up_r ##1 center_aligned_pwm_r && !up_r);
  capture_c: cover property (@(posedge core_clk_i) disable iff (!rstn_i)
    !center_aligned_pwm_r && mode_r[0] == MODE_CAPTURE && channel_owned_o[0] && sync_rise[0]);
  ext_clock_c: cover property (@(posedge core_clk_i) disable iff (!rstn_i)
    cks_r == CKS_EXT && cnt_tick);
  epwm_c: cover property (@(posedge core_clk_i) disable iff (!rstn_i)
    !center_aligned_pwm_r && mode_r[0][1] && channel_pin_oe_o[0] && period_start);
endmodule // timer_channel_pin_control

// ===== timer_channel_pin_control_tb.sv
// Self-checking bench for the timer pin control block over APB
module timer_channel_pin_control_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import timer_pkg::*;
  logic core_clk, rstn, psel, penable, pwrite, fix_tick, ext_clk, pready, pslverr, err_r;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q, q0;
  logic [1:0] pin_i, pin_o, pin_oe, owned, e;
  int failures, samples_checked, cyc;
  logic [1:0] cap_els [6] = '{2'h1, 2'h1, 2'h2, 2'h2, 2'h3, 2'h3};
  logic cap_exp [6] = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1};
  logic [1:0] cmp_els [3] = '{2'h1, 2'h3, 2'h2};
  logic cmp_exp [3] = '{1'b0, 1'b1, 1'b0};

  timer_channel_pin_control #(.NUM_CH(2)) i_timer_channel_pin_control (
    .core_clk_i(core_clk), .rstn_i(rstn), .paddr_i(paddr), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .fixed_clk_tick_i(fix_tick),
    .external_timer_clock_input_i(ext_clk), .channel_pin_i(pin_i),
    .channel_pin_o(pin_o), .channel_pin_oe_o(pin_oe), .channel_owned_o(owned));

  pin_partner #(.N(2)) i_pin_partner (
    .core_clk_i(core_clk), .pin_drv_i(pin_o), .pin_oe_i(pin_oe),
    .pin_lvl_o(pin_i), .ext_clk_o(ext_clk));

  // -------------------------------------------------------------
  // Clock, timeout and verdict
  // -------------------------------------------------------------
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end

  // Cut a hang short well beyond the few hundred cycles the tests need
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      close_out();
    end
  end

  task automatic close_out();
    if (failures == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // -------------------------------------------------------------
  // Bus and stimulus tasks
  // -------------------------------------------------------------
  // One APB transfer: setup, access held until pready, then release
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge core_clk);
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    psel <= 1'b1;
    @(posedge core_clk);
    penable <= 1'b1;
    @(posedge core_clk);
    while (pready !== 1'b1 && n < 20) begin
      n++;
      @(posedge core_clk);
    end
    if (n == 20) failures++;
    q = prdata;
    err_r = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(a, 1'b1, d);
  endtask

  task automatic rd(input logic [7:0] a);
    apb(a, 1'b0, 32'h0);
  endtask

  // Fixed-source ticks two cycles apart, then let the pins settle
  task automatic tick(input int n);
    repeat (n) begin
      @(posedge core_clk);
      fix_tick <= 1'b1;
      @(posedge core_clk);
      fix_tick <= 1'b0;
    end
    repeat (4) @(posedge core_clk);
    #1;
  endtask

  // -------------------------------------------------------------
  // Test sequence
  // -------------------------------------------------------------
  initial begin
    rstn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    fix_tick = 1'b0;
    repeat (2) @(posedge core_clk);
    rstn <= 1'b1;
    // Reset state, then an unmapped place
    rd(CTRL_OFS);
    chk(q, 32'h0);
    chk({owned, pin_oe}, 32'h0);
    rd(8'h80);
    chk({q[30:0], err_r}, 32'h1);
    // Clock off, bus rate and fixed source
    wr(CH_BASE_OFS, 32'h14);
    wr(CTRL_OFS, 32'h0);
    wr(CNT_OFS, 32'h0);
    tick(3);
    rd(CNT_OFS);
    chk(q, 32'h0);
    chk(owned, 32'h0);
    wr(CTRL_OFS, 32'h08);
    rd(CNT_OFS);
    q0 = q;
    rd(CNT_OFS);
    chk(q - q0, 32'h3);
    wr(CTRL_OFS, 32'h10);
    wr(CNT_OFS, 32'h0);
    tick(4);
    rd(CNT_OFS);
    chk(q, 32'h4);
    // Prescaler divide by two on the fixed source
    wr(CTRL_OFS, 32'h11);
    wr(CNT_OFS, 32'h0);
    tick(4);
    rd(CNT_OFS);
    chk(q, 32'h2);
    wr(CTRL_OFS, 32'h10);
    // Output compare: level kept on takeover, then toggle, set, clear
    wr(CH_BASE_OFS, 32'h0);
    i_pin_partner.set_level(2'b01);
    wr(8'h14, 32'h3);
    wr(MOD_OFS, 32'h7);
    wr(CH_BASE_OFS, 32'h14);
    tick(0);
    chk({pin_oe[0], pin_o[0]}, 32'h3);
    for (int i = 0; i < 3; i++) begin
      wr(CH_BASE_OFS, {26'h0, 2'h1, cmp_els[i], 2'h0});
      wr(CNT_OFS, 32'h0);
      tick(3);
      chk(pin_o[0], cmp_exp[i]);
    end
    // External clock with a software-only compare channel
    wr(CTRL_OFS, 32'h18);
    wr(CH_BASE_OFS, 32'h10);
    wr(CNT_OFS, 32'h0);
    wr(FLAG_OFS, 32'h3);
    i_pin_partner.ext_pulses(3);
    rd(CNT_OFS);
    chk(q, 32'h3);
    rd(FLAG_OFS);
    chk(q[0], 32'h1);
    chk(owned[0], 32'h0);
    // Capture on each edge select, counter frozen at five
    wr(CTRL_OFS, 32'h10);
    wr(CH_BASE_OFS, 32'h0);
    i_pin_partner.set_level(2'b00);
    wr(CNT_OFS, 32'h0);
    tick(5);
    for (int i = 0; i < 6; i++) begin
      wr(CH_BASE_OFS, {28'h0, cap_els[i], 2'h0});
      wr(FLAG_OFS, 32'h3);
      i_pin_partner.set_level({1'b0, ~i[0]});
      rd(FLAG_OFS);
      chk(q[0], cap_exp[i]);
    end
    rd(8'h14);
    chk(q, 32'h5);
    chk({owned[0], pin_oe[0]}, 32'h2);
    // Edge PWM on both high-bit mode codes, both polarities
    wr(8'h1C, 32'h3);
    for (int i = 2; i < 4; i++) begin
      e = i[1:0];
      wr(CH_BASE_OFS, {26'h0, 2'h2, e, 2'h0});
      wr(8'h18, {26'h0, 2'h3, e, 2'h0});
      wr(CNT_OFS, 32'h0);
      tick(3);
      chk(pin_o, {2{e[0]}});
      tick(5);
      chk(pin_o, {2{~e[0]}});
    end
    // Center PWM: both channels left in capture mode, channel 1 inverted polarity
    wr(CH_BASE_OFS, 32'h08);
    wr(8'h18, 32'h04);
    wr(MOD_OFS, 32'h4);
    wr(8'h14, 32'h2);
    wr(8'h1C, 32'h2);
    wr(CTRL_OFS, 32'h30);
    wr(CNT_OFS, 32'h0);
    tick(2);
    chk({pin_oe, pin_o}, 32'hE);
    tick(3);
    rd(CNT_OFS);
    chk(q, 32'h3);
    rd(FLAG_OFS);
    chk(q[DIR_BIT], 32'h0);
    tick(1);
    chk(pin_o, 32'h1);
    close_out();
  end
endmodule // timer_channel_pin_control_tb

// ===== timer_pkg.sv
// Package of offsets, field positions, reset values and codes for the timer pin control block
package timer_pkg;
  localparam int CNT_W = 16;
  localparam int ADDR_W = 8;
  localparam int SYNC_STAGES = 2;
  // Register byte offsets
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] CNT_OFS = 8'h04;
  localparam logic [7:0] MOD_OFS = 8'h08;
  localparam logic [7:0] FLAG_OFS = 8'h0C;
  localparam logic [7:0] CH_BASE_OFS = 8'h10;
  localparam logic [7:0] CH_STRIDE = 8'h08;
  localparam logic [7:0] CH_VAL_OFS = 8'h04;
  // Control register fields, then the direction bit of the flag register
  localparam int PS_LSB = 0;
  localparam int CKS_LSB = 3;
  localparam int CENTER_ALIGNED_PWM_BIT = 5;
  localparam int DIR_BIT = 16;
  // Channel control fields
  localparam int ELS_LSB = 2;
  localparam int MODE_LSB = 4;
  // Reset values
  localparam logic [CNT_W-1:0] CNT_RST = 16'h0000;
  localparam logic [CNT_W-1:0] MOD_RST = 16'h0000;
  localparam logic [6:0] PRE_RST = 7'h00;
  // Clock source select codes
  localparam logic [1:0] CKS_OFF = 2'h0;
  localparam logic [1:0] CKS_BUS = 2'h1;
  localparam logic [1:0] CKS_FIXED = 2'h2;
  localparam logic [1:0] CKS_EXT = 2'h3;
  // Edge/level select codes
  localparam logic [1:0] ELS_NONE = 2'h0;
  localparam logic [1:0] ELS_TOGGLE = 2'h1;
  localparam logic [1:0] ELS_CLEAR = 2'h2;
  localparam logic [1:0] ELS_SET = 2'h3;
  // Channel mode select codes
  typedef enum logic [1:0] {
    MODE_CAPTURE = 2'b00,
    MODE_COMPARE = 2'b01,
    MODE_EPWM = 2'b10,
    MODE_EPWM_ALT = 2'b11
  } ch_mode_t;
endpackage
